// ===== dv/ghp_host_model.sv
`timescale 1ns/100ps
module ghp_host_model
  import ghp_pkg::*;
(
  input wire logic mclk,
  output ghp_pins_t pins,
  input wire logic [GHP_DW-1:0] host_data_out,
  input wire logic host_access_ready
);
  int hung = 0;
  int early = 0;

  // pins idle until the first access
  initial begin
    pins = '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};
  end

  // one whole host access: select, strobe, wait for ready, release
  task automatic access(input logic we, input logic [GHP_AW-1:0] a,
      input logic [GHP_LANES-1:0] l, input logic [GHP_DW-1:0] d,
      output logic [GHP_DW-1:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    #1;
    pins = {1'b0, 1'b1, 1'b1, l, a, d};
    repeat (2) @(posedge mclk);
    #1;
    if (host_access_ready === 1'b1) early++;
    if (we) pins.wr_n = 1'b0;
    else pins.rd_n = 1'b0;
    do @(posedge mclk); while (host_access_ready !== 1'b1 && n++ < 40);
    q = host_data_out;
    if (n >= 40) hung++;
    #1;
    // strobe gone, so the data lines no longer carry the word
    pins = {1'b0, 1'b1, 1'b1, l, a, ~d};
    n = 0;
    while (host_access_ready !== 1'b0 && n++ < 10) @(posedge mclk);
    #1;
    pins = {1'b1, 1'b1, 1'b1, ~l, ~a, ~d};
    repeat (3) @(posedge mclk);
  endtask
endmodule

// ===== dv/graphics_host_port_test.sv
`timescale 1ns/100ps
module graphics_host_port_test
  import ghp_pkg::*;
();
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  ghp_pins_t pins;
  ghp_mem_req_t mem_req;
  logic [GHP_DW-1:0] data_out, mem_rdata, q, exp_d;
  logic oe, ready, irq, mem_ack, msg_wr, irq_set, in_clr, proc_rst, exp_we;
  logic exp_mem = 1'b0;
  logic [2:0] msg_code;
  logic [15:0] ctl_low;
  logic [3:0] exp_be;
  logic [GHP_AW-1:0] exp_a;
  int bad_count = 0;
  int n_compared = 0;
  int seed = 32'hc402;

  always #2 mclk = ~mclk;

  ghp_host_port dut (.mclk(mclk), .reset_n(reset_n), .host_word_addr(pins.waddr),
    .host_lane_select(pins.lanes), .host_select_n(pins.sel_n),
    .host_rd_strobe_n(pins.rd_n), .host_wr_strobe_n(pins.wr_n),
    .host_data_in(pins.wdata), .host_data_out(data_out), .host_out_enable(oe),
    .host_access_ready(ready), .host_irq_out(irq), .mem_req(mem_req),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .proc_msg_wr(msg_wr),
    .proc_msg_code(msg_code), .proc_irq_set(irq_set), .proc_irq_in_clr(in_clr),
    .proc_ctl_low(ctl_low), .proc_reset_out(proc_rst));

  ghp_host_model host (.mclk(mclk), .pins(pins), .host_data_out(data_out),
    .host_access_ready(ready));

  function automatic logic [31:0] rd_val(input logic [GHP_AW-1:0] a);
    return {5'h00, a} ^ 32'hA5C33C5A;
  endfunction

  function automatic logic [31:0] lm(input logic [3:0] l);
    return {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}};
  endfunction

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_compared++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  task automatic pulse(ref logic s);
    @(posedge mclk) #1 s = 1'b1;
    @(posedge mclk) #1 s = 1'b0;
  endtask

  task reg_wr(input logic [GHP_AW-1:0] a, input logic [3:0] l, input logic [31:0] d);
    host.access(1'b1, a, l, d, q);
  endtask

  task summarize;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // processor memory: random latency, one-cycle ack, garbage after it
  initial begin
    mem_ack = 1'b0;
    mem_rdata = '0;
    forever begin
      @(posedge mclk);
      if (mem_req.req === 1'b1) begin
        chk("mem_req", {exp_mem, exp_we, exp_be, exp_a},
          {1'b1, mem_req.we, mem_req.be, mem_req.addr});
        if (exp_we) chk("mem_wdata", exp_d, mem_req.wdata);
        chk("host_oe", !exp_we, oe);
        repeat ($unsigned($random(seed)) % 4) @(posedge mclk);
        #1 mem_ack = 1'b1;
        mem_rdata = rd_val(mem_req.addr);
        @(posedge mclk) #1 mem_ack = 1'b0;
        mem_rdata = ~mem_rdata;
        @(posedge mclk);
      end
    end
  end

  // watchdog
  initial begin
    #100000;
    bad_count++;
    summarize;
  end

  // main sequence
  initial begin
    msg_wr = 1'b0;
    msg_code = 3'h0;
    irq_set = 1'b0;
    in_clr = 1'b0;
    repeat (16) @(posedge mclk);
    #1 reset_n = 1'b1;
    chk("reset", 21'h000000, {ctl_low, proc_rst, ready, irq, mem_req.req, oe});
    $display("test reset done");
    reg_wr(GHP_CTL_LOW_WORD, 4'b0100, 32'h000D0000);
    chk("ctl_low", 16'h000D, ctl_low);
    msg_code = 3'h6;
    pulse(msg_wr);
    chk("ctl_low", 16'h006D, ctl_low);
    pulse(irq_set);
    repeat (2) @(posedge mclk);
    chk("irq", {16'h00ED, 1'b1}, {ctl_low, irq});
    host.access(1'b0, GHP_CTL_LOW_WORD, 4'b1100, '0, q);
    chk("rd_low", 32'h00ED0000, q);
    reg_wr(GHP_CTL_LOW_WORD, 4'b0100, 32'h00800000);
    chk("ctl_low", 16'h00E8, ctl_low);
    reg_wr(GHP_CTL_LOW_WORD, 4'b0100, 32'h00000000);
    repeat (2) @(posedge mclk);
    chk("irq", {16'h0068, 1'b0}, {ctl_low, irq});
    reg_wr(GHP_CTL_LOW_WORD, 4'b1011, 32'hFFFFFFFF);
    chk("ctl_low", 16'h0068, ctl_low);
    pulse(in_clr);
    chk("ctl_low", 16'h0060, ctl_low);
    $display("test control low done");
    reg_wr(GHP_CTL_HIGH_WORD, 4'b0001, 32'h00000080);
    chk("proc_rst", {1'b1, 16'h0060}, {proc_rst, ctl_low});
    host.access(1'b0, GHP_CTL_HIGH_WORD, 4'b0011, '0, q);
    chk("rd_high", 32'h00000080, q);
    reg_wr(GHP_CTL_HIGH_WORD, 4'b0001, 32'h00000000);
    chk("proc_rst", 1'b0, proc_rst);
    $display("test control high done");
    // random memory traffic, away from the control words
    repeat (24) begin
      exp_we = 1'($random(seed));
      exp_be = 4'($random(seed));
      exp_a = GHP_AW'($random(seed));
      exp_a[26] = 1'b0;
      exp_d = $random(seed);
      exp_mem = 1'b1;
      host.access(exp_we, exp_a, exp_be, exp_d, q);
      exp_mem = 1'b0;
      if (!exp_we) chk("rd_mem", rd_val(exp_a) & lm(exp_be), q);
    end
    $display("test memory done");
    chk("early_ready", 0, host.early);
    chk("host_hung", 0, host.hung);
    summarize;
  end
endmodule

// ===== verilog/ghp_host_port.sv
`timescale 1ns/100ps
module ghp_host_port
  import ghp_pkg::*;
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [GHP_AW-1:0] host_word_addr,
  input wire logic [GHP_LANES-1:0] host_lane_select,
  input wire logic host_select_n,
  input wire logic host_rd_strobe_n,
  input wire logic host_wr_strobe_n,
  input wire logic [GHP_DW-1:0] host_data_in,
  output logic [GHP_DW-1:0] host_data_out,
  output logic host_out_enable,
  output logic host_access_ready,
  output logic host_irq_out,
  output ghp_mem_req_t mem_req,
  input wire logic mem_ack,
  input wire logic [GHP_DW-1:0] mem_rdata,
  input wire logic proc_msg_wr,
  input wire logic [GHP_MSG_W-1:0] proc_msg_code,
  input wire logic proc_irq_set,
  input wire logic proc_irq_in_clr,
  output logic [15:0] proc_ctl_low,
  output logic proc_reset_out
);
  localparam ghp_pins_t PINS_IDLE = '{sel_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, default: '0};

  ghp_pins_t pin_d;
  ghp_pins_t pin_s;
  ghp_state_t state_r, state_nxt;
  logic sel_n_d_r;
  logic [GHP_AW-1:0] waddr_r;
  logic [GHP_LANES-1:0] lanes_r;
  logic [15:0] ctl_low_r, ctl_low_nxt;
  logic [15:0] ctl_high_r, ctl_high_nxt;
  ghp_mem_req_t mem_req_r, mem_req_nxt;
  logic [GHP_DW-1:0] rdata_r, rdata_nxt;
  logic ready_r;
  logic oe_r;
  logic irq_pin_r;

  assign pin_d = '{sel_n: host_select_n, rd_n: host_rd_strobe_n, wr_n: host_wr_strobe_n,
                   lanes: host_lane_select, waddr: host_word_addr, wdata: host_data_in};

  ghp_sync #(.WIDTH($bits(ghp_pins_t)), .INIT(PINS_IDLE)) u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .d(pin_d),
    .q(pin_s)
  );

  // access decode on the latched address
  logic sel_fall_w, strobe_w, rd_w, wr_w, low_hit_w, high_hit_w, reg_hit_w;
  logic [GHP_DW-1:0] lane_bits_w;
  logic [15:0] wr_low_w, wr_high_w;
  logic host_low_wr_w, host_high_wr_w, irq_in_set_w, irq_out_clr_w;
  assign sel_fall_w = sel_n_d_r & ~pin_s.sel_n;
  assign rd_w = ~pin_s.sel_n & ~pin_s.rd_n;
  assign wr_w = ~pin_s.sel_n & ~pin_s.wr_n & pin_s.rd_n;
  assign strobe_w = rd_w | wr_w;
  assign low_hit_w = (waddr_r == GHP_CTL_LOW_WORD);
  assign high_hit_w = (waddr_r == GHP_CTL_HIGH_WORD);
  assign reg_hit_w = low_hit_w | high_hit_w;
  assign wr_low_w = pin_s.wdata[GHP_CTL_LOW_SHIFT +: 16];
  assign wr_high_w = pin_s.wdata[GHP_CTL_HIGH_SHIFT +: 16];
  assign host_low_wr_w = (state_r == GHP_CMD) & wr_w & low_hit_w
                         & lanes_r[GHP_CTL_LOW_LANE];
  assign host_high_wr_w = (state_r == GHP_CMD) & wr_w & high_hit_w
                          & lanes_r[GHP_CTL_HIGH_LANE];
  assign irq_in_set_w = host_low_wr_w & wr_low_w[GHP_IRQ_IN_BIT];
  assign irq_out_clr_w = host_low_wr_w & ~wr_low_w[GHP_IRQ_OUT_BIT];

  // lane expansion for read masking
  for (genvar g = 0; g < GHP_LANES; g++) begin : g_lane
    assign lane_bits_w[g*8 +: 8] = {8{lanes_r[g]}};
  end

  // control register next values; on both interrupt flags a set beats a clear
  always_comb begin
    ctl_low_nxt = ctl_low_r;
    ctl_high_nxt = ctl_high_r;
    if (host_low_wr_w) begin
      ctl_low_nxt[GHP_MSG_IN_LSB +: GHP_MSG_W] = wr_low_w[GHP_MSG_IN_LSB +: GHP_MSG_W];
    end
    if (proc_msg_wr) begin
      ctl_low_nxt[GHP_MSG_OUT_LSB +: GHP_MSG_W] = proc_msg_code;
    end
    if (proc_irq_in_clr) begin
      ctl_low_nxt[GHP_IRQ_IN_BIT] = 1'b0;
    end
    if (irq_in_set_w) begin
      ctl_low_nxt[GHP_IRQ_IN_BIT] = 1'b1;
    end
    if (irq_out_clr_w) begin
      ctl_low_nxt[GHP_IRQ_OUT_BIT] = 1'b0;
    end
    if (proc_irq_set) begin
      ctl_low_nxt[GHP_IRQ_OUT_BIT] = 1'b1;
    end
    if (host_high_wr_w) begin
      ctl_high_nxt[GHP_RST_BIT] = wr_high_w[GHP_RST_BIT];
    end
    ctl_low_nxt = ctl_low_nxt & GHP_CTL_LOW_MASK;
    ctl_high_nxt = ctl_high_nxt & GHP_CTL_HIGH_MASK;
  end

  // access sequencer: latch, run access, hold ready until strobe release
  always_comb begin
    state_nxt = state_r;
    mem_req_nxt = mem_req_r;
    rdata_nxt = rdata_r;
    unique case (state_r)
      GHP_IDLE: begin
        if (sel_fall_w) begin
          state_nxt = GHP_CMD;
        end
      end
      GHP_CMD: begin
        if (pin_s.sel_n) begin
          state_nxt = GHP_IDLE;
        end else if (strobe_w && reg_hit_w) begin
          rdata_nxt = '0;
          rdata_nxt[GHP_CTL_LOW_SHIFT +: 16] = low_hit_w ? ctl_low_r : 16'h0000;
          rdata_nxt[GHP_CTL_HIGH_SHIFT +: 16] = high_hit_w ? ctl_high_r : 16'h0000;
          rdata_nxt = rdata_nxt & lane_bits_w;
          state_nxt = GHP_DONE;
        end else if (strobe_w) begin
          mem_req_nxt = '{req: 1'b1, we: wr_w, be: lanes_r, addr: waddr_r,
                          wdata: pin_s.wdata};
          state_nxt = GHP_MEM;
        end
      end
      GHP_MEM: begin
        if (mem_ack) begin
          mem_req_nxt.req = 1'b0;
          rdata_nxt = mem_rdata & lane_bits_w;
          state_nxt = GHP_DONE;
        end
      end
      GHP_DONE: begin
        if (pin_s.rd_n && pin_s.wr_n) begin
          state_nxt = GHP_CMD;
        end
      end
    endcase
  end

  // sequencer and latch registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= GHP_IDLE;
      sel_n_d_r <= 1'b1;
      waddr_r <= '0;
      lanes_r <= '0;
      mem_req_r <= '0;
      rdata_r <= '0;
    end else begin
      state_r <= state_nxt;
      sel_n_d_r <= pin_s.sel_n;
      if (state_r == GHP_IDLE && sel_fall_w) begin
        waddr_r <= pin_s.waddr;
        lanes_r <= pin_s.lanes;
      end
      mem_req_r <= mem_req_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // pin-facing and control registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ready_r <= 1'b0;
      oe_r <= 1'b0;
      irq_pin_r <= 1'b0;
      ctl_low_r <= GHP_CTL_LOW_RST;
      ctl_high_r <= GHP_CTL_HIGH_RST;
    end else begin
      ready_r <= (state_nxt == GHP_DONE);
      oe_r <= rd_w;
      irq_pin_r <= ctl_low_r[GHP_IRQ_OUT_BIT];
      ctl_low_r <= ctl_low_nxt;
      ctl_high_r <= ctl_high_nxt;
    end
  end

  assign host_data_out = rdata_r;
  assign host_out_enable = oe_r;
  assign host_access_ready = ready_r;
  assign host_irq_out = irq_pin_r;
  assign mem_req = mem_req_r;
  assign proc_ctl_low = ctl_low_r;
  assign proc_reset_out = ctl_high_r[GHP_RST_BIT];

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_latch_on_select: assert property ((state_r == GHP_IDLE) && sel_fall_w |=>
    waddr_r == $past(pin_s.waddr) && lanes_r == $past(pin_s.lanes))
    else $error("address or lanes not latched on select");
  a_lane_mem_be: assert property ($rose(mem_req_r.req) |-> mem_req_r.be == lanes_r)
    else $error("memory lane enables differ from lanes");
  a_lane_reg_skip: assert property ((state_r == GHP_CMD) && wr_w && low_hit_w
    && !lanes_r[GHP_CTL_LOW_LANE] && !proc_msg_wr |=> $stable(ctl_low_r[2:0]))
    else $error("unselected lane changed message");
  a_ready_cause: assert property ($rose(host_access_ready) |->
    ($past(state_r) == GHP_MEM && $past(mem_ack))
    || ($past(state_r) == GHP_CMD && $past(reg_hit_w) && $past(strobe_w)))
    else $error("ready without completed access");
  a_ready_drop: assert property (host_access_ready && pin_s.rd_n && pin_s.wr_n
    |=> !host_access_ready)
    else $error("ready held after strobe release");
  a_irq_in_set: assert property (irq_in_set_w |=> ctl_low_r[GHP_IRQ_IN_BIT])
    else $error("host interrupt flag not set");
  a_irq_out_set: assert property (proc_irq_set |=> ctl_low_r[GHP_IRQ_OUT_BIT])
    else $error("processor interrupt flag not set");
  a_msg_in_write: assert property (host_low_wr_w |=>
    ctl_low_r[GHP_MSG_IN_LSB +: GHP_MSG_W] == $past(wr_low_w[GHP_MSG_IN_LSB +: GHP_MSG_W]))
    else $error("host message not stored");
  a_msg_out_write: assert property (proc_msg_wr |=>
    ctl_low_r[GHP_MSG_OUT_LSB +: GHP_MSG_W] == $past(proc_msg_code))
    else $error("processor message not stored");
  a_reset_bit: assert property (host_high_wr_w |=>
    proc_reset_out == $past(wr_high_w[GHP_RST_BIT]))
    else $error("processor reset bit not stored");
  a_irq_pin_follow: assert property (ctl_low_r[GHP_IRQ_OUT_BIT] != host_irq_out
    |=> host_irq_out == $past(ctl_low_r[GHP_IRQ_OUT_BIT]))
    else $error("interrupt pin does not follow flag");

  c_reg_read: cover property ((state_r == GHP_CMD) && rd_w && reg_hit_w ##1 host_access_ready);
  c_mem_write: cover property (mem_req_r.req && mem_req_r.we ##[1:20] host_access_ready);
  c_irq_loop: cover property ($rose(host_irq_out) ##[1:50] $fell(host_irq_out));
endmodule

// ===== verilog/ghp_pkg.sv
package ghp_pkg;
  localparam int GHP_AW = 27;
  localparam int GHP_DW = 32;
  localparam int GHP_LANES = 4;
  localparam int GHP_WADDR_LSB = 5;
  // control registers sit at bit addresses; a word holds two 16-bit halves
  localparam logic [31:0] GHP_CTL_LOW_OFS = 32'hC00000F0;
  localparam logic [31:0] GHP_CTL_HIGH_OFS = 32'hC0000100;
  localparam logic [GHP_AW-1:0] GHP_CTL_LOW_WORD = GHP_CTL_LOW_OFS[31:GHP_WADDR_LSB];
  localparam logic [GHP_AW-1:0] GHP_CTL_HIGH_WORD = GHP_CTL_HIGH_OFS[31:GHP_WADDR_LSB];
  localparam int GHP_CTL_LOW_SHIFT = GHP_CTL_LOW_OFS[4] ? 16 : 0;
  localparam int GHP_CTL_HIGH_SHIFT = GHP_CTL_HIGH_OFS[4] ? 16 : 0;
  localparam int GHP_CTL_LOW_LANE = GHP_CTL_LOW_SHIFT / 8;
  localparam int GHP_CTL_HIGH_LANE = GHP_CTL_HIGH_SHIFT / 8;
  // low control fields
  localparam int GHP_MSG_IN_LSB = 0;
  localparam int GHP_MSG_W = 3;
  localparam int GHP_IRQ_IN_BIT = 3;
  localparam int GHP_MSG_OUT_LSB = 4;
  localparam int GHP_IRQ_OUT_BIT = 7;
  // high control field
  localparam int GHP_RST_BIT = 7;
  localparam logic [15:0] GHP_CTL_LOW_RST = 16'h0000;
  localparam logic [15:0] GHP_CTL_HIGH_RST = 16'h0000;
  localparam logic [15:0] GHP_CTL_LOW_MASK = 16'h00FF;
  localparam logic [15:0] GHP_CTL_HIGH_MASK = 16'h0080;

  // host pins that are resynchronised together
  typedef struct packed {
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic [GHP_LANES-1:0] lanes;
    logic [GHP_AW-1:0] waddr;
    logic [GHP_DW-1:0] wdata;
  } ghp_pins_t;

  // request toward processor memory
  typedef struct packed {
    logic req;
    logic we;
    logic [GHP_LANES-1:0] be;
    logic [GHP_AW-1:0] addr;
    logic [GHP_DW-1:0] wdata;
  } ghp_mem_req_t;

  typedef enum logic [1:0] {GHP_IDLE, GHP_CMD, GHP_MEM, GHP_DONE} ghp_state_t;
endpackage

// ===== verilog/ghp_sync.sv
`timescale 1ns/100ps
module ghp_sync
  import ghp_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] q_r;

  // two stages; only the second stage is visible
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      meta_r <= INIT;
      q_r <= INIT;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;
endmodule
